// ### hwd_host_model.sv
`timescale 1ns/100ps
// host on the serial command bus: sends frames, collects replies
module hwd_host_model (
  input wire logic mclk, // system clock
  output logic [7:0] rx_data, // char to the block
  output logic rx_valid, // char strobe
  output logic rx_err, // link error strobe
  input wire logic [7:0] tx_data, // reply char
  input wire logic tx_valid, // reply char offered
  output logic tx_ready // reply char taken
);
  import hwd_pkg::*;
  logic [63:0] rep; // reply text without cr
  logic got_cr; // reply finished
  bit slow; // stall the reply every other cycle
  initial begin
    rx_data = 8'h00;
    rx_valid = 1'b0;
    rx_err = 1'b0;
    tx_ready = 1'b1;
    rep = '0;
    got_cr = 1'b0;
  end
  // ready toggles when slow, so the block must hold each char
  always @(posedge mclk) tx_ready <= slow ? ~tx_ready : 1'b1;
  // capture reply chars only at accepted edges
  always @(posedge mclk) begin
    if (tx_valid && tx_ready) begin
      if (tx_data == CH_CR) got_cr <= 1'b1;
      else rep <= {rep[55:0], tx_data};
    end
  end
  // frame is tilde, address, command, params, cr; a '#' sends a link error
  task automatic xfer(input string s, output logic [63:0] r);
    int n;
    rep = '0;
    got_cr = 1'b0;
    for (int i = 0; i <= s.len(); i++) begin
      @(posedge mclk);
      rx_err <= (i < s.len()) && (s[i] == "#");
      rx_valid <= !((i < s.len()) && (s[i] == "#"));
      rx_data <= (i < s.len()) ? s[i] : CH_CR;
    end
    @(posedge mclk);
    rx_valid <= 1'b0;
    rx_err <= 1'b0;
    rx_data <= ~rx_data; // released line shows no stale char
    n = 0;
    while (!got_cr && n < 60) begin
      @(posedge mclk);
      n++;
    end
    r = rep;
  endtask
endmodule

// ### hwd_pkg.sv
package hwd_pkg;

  // timing: the watchdog counts in tenths of a second
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned TICK_MS = 100;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;

  // frame body limits, in characters after the tilde
  localparam int unsigned RX_MAX = 8;
  localparam logic [3:0] MIN_BODY = 4'h3;
  localparam logic [3:0] CKS_CHARS = 4'h2;

  // ascii characters of the command set
  localparam logic [7:0] CH_TILDE = 8'h7e;
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_BANG = 8'h21;
  localparam logic [7:0] CH_QUERY = 8'h3f;
  localparam logic [7:0] CH_0 = 8'h30;
  localparam logic [7:0] CH_1 = 8'h31;
  localparam logic [7:0] CH_2 = 8'h32;
  localparam logic [7:0] CH_3 = 8'h33;
  localparam logic [7:0] CH_4 = 8'h34;
  localparam logic [7:0] CH_P = 8'h50;
  localparam logic [7:0] CH_S = 8'h53;

  // apb register offsets
  localparam logic [7:0] OFS_ID = 8'h00;
  localparam logic [7:0] OFS_WDT = 8'h04;
  localparam logic [7:0] OFS_DOUT = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0c;
  localparam logic [7:0] OFS_MASK = 8'h10;

  // field positions
  localparam int ID_CKS_BIT = 8;
  localparam int WDT_EN_BIT = 8;
  localparam int WDT_FLAG_BIT = 9;
  localparam int WDT_CNT_LSB = 16;
  localparam int DOUT_SAFE_BIT = 4;
  localparam int DOUT_PON_BIT = 5;
  localparam int ST_EN_BIT = 7;
  localparam int ST_TO_BIT = 2;
  localparam int EV_TIMEOUT = 0;
  localparam int EV_REPLY = 1;
  localparam int EV_DROP = 2;
  localparam int NEV = 3;

  // values after reset
  localparam logic [7:0] STATION_RST = 8'h01;
  localparam logic [7:0] TENTHS_RST = 8'h00;

  typedef enum logic {HWD_IDLE, HWD_BODY} hwd_rx_t;

  function automatic logic [7:0] hwd_hex_chr(input logic [3:0] n);
    return (n < 4'ha) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
  endfunction

  // returns {valid, nibble}; upper and lower case accepted
  function automatic logic [4:0] hwd_hex_val(input logic [7:0] c);
    logic [4:0] v;
    v = 5'h00;
    if (c >= 8'h30 && c <= 8'h39)
      v = {1'b1, c[3:0]};
    else if ((c >= 8'h41 && c <= 8'h46) || (c >= 8'h61 && c <= 8'h66))
      v = {1'b1, c[3:0] + 4'h9};
    return v;
  endfunction

endpackage

// ### hwd_tick.sv
`timescale 1ns/100ps
module hwd_tick #(
  parameter int unsigned CYCLES = hwd_pkg::TICK_CYCLES
) (
  input wire logic mclk, // system clock
  input wire logic reset, // sync reset, high
  input wire logic clr, // restart the interval
  output logic tick // one-cycle enable per interval
);
  localparam int W = $clog2(CYCLES + 1);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;

  // free count, restarted so a kick gives a full first interval
  always_comb begin
    cnt_d = cnt_q + 1'b1;
    if (clr || cnt_q == W'(CYCLES - 1))
      cnt_d = '0;
  end

  always_ff @(posedge mclk) begin
    if (reset)
      cnt_q <= '0;
    else
      cnt_q <= cnt_d;
  end

  assign tick = !clr && cnt_q == W'(CYCLES - 1);
endmodule

// ### hwd_tx.sv
`timescale 1ns/100ps
module hwd_tx (
  input wire logic mclk, // system clock
  input wire logic reset, // sync reset, high
  input wire logic start, // send request, taken when idle
  input wire logic [47:0] chars, // reply text, first char low
  input wire logic [2:0] len, // chars used, 3..6
  input wire logic cks_en, // append sum digits
  output logic [7:0] tx_data, // current character
  output logic tx_valid, // character offered
  input wire logic tx_ready, // sink takes character
  output logic busy // reply in progress
);
  import hwd_pkg::*;
  logic busy_q, busy_d, cks_q, cks_d;
  logic [3:0] idx_q, idx_d, nidx, last;
  logic [7:0] data_q, data_d, sum_q, sum_d, nchr;
  logic [47:0] chars_q, chars_d;
  logic [2:0] len_q, len_d;

  // next character: text, then optional sum digits, then cr
  always_comb begin
    nidx = idx_q + 4'h1;
    last = {1'b0, len_q} + (cks_q ? CKS_CHARS : 4'h0);
    nchr = CH_CR;
    if (nidx < {1'b0, len_q})
      nchr = chars_q[{nidx[2:0], 3'b000} +: 8];
    else if (cks_q && nidx == {1'b0, len_q})
      nchr = hwd_hex_chr(sum_q[7:4]);
    else if (cks_q && nidx == {1'b0, len_q} + 4'h1)
      nchr = hwd_hex_chr(sum_q[3:0]);
    busy_d = busy_q;
    idx_d = idx_q;
    data_d = data_q;
    sum_d = sum_q;
    chars_d = chars_q;
    len_d = len_q;
    cks_d = cks_q;
    if (start && !busy_q) begin
      busy_d = 1'b1;
      idx_d = 4'h0;
      data_d = chars[7:0];
      sum_d = chars[7:0];
      chars_d = chars;
      len_d = len;
      cks_d = cks_en;
    end else if (busy_q && tx_ready) begin
      if (idx_q == last) begin
        busy_d = 1'b0;
      end else begin
        idx_d = nidx;
        data_d = nchr;
        if (nidx < {1'b0, len_q})
          sum_d = sum_q + nchr;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      busy_q <= 1'b0;
      idx_q <= 4'h0;
      data_q <= 8'h00;
      sum_q <= 8'h00;
      chars_q <= 48'h0;
      len_q <= 3'h0;
      cks_q <= 1'b0;
    end else begin
      busy_q <= busy_d;
      idx_q <= idx_d;
      data_q <= data_d;
      sum_q <= sum_d;
      chars_q <= chars_d;
      len_q <= len_d;
      cks_q <= cks_d;
    end
  end

  assign tx_data = data_q;
  assign tx_valid = busy_q;
  assign busy = busy_q;
endmodule

// ### hwd_wdog.sv
// Summary of operation
// R01: frame is tilde, address, command, check, cr
// R02: valid gives bang plus address, invalid question
// R03: bad syntax, link error, other address: silence
// R04: status byte bit 2 marks timeout
// R05: status bit 7 shows watchdog enabled
// R06: disabled and no timeout reads 00
// R07: timeout flag kept nonvolatile, cleared only by command
// R08: clear command drops flag and acknowledges
// R09: timeout read returns enable digit and value
// R10: value counts tenths of a second
// R11: configure sets enable, value, then acknowledges
// R12: timeout records flag and disables watchdog
// R13: preset read returns power-on or safe value
// R14: timeout drives output to safe value
// R15: power-on value loads output after reset
// R16: valid addressed command restarts the countdown
// R17: 100 ms tick decrements, enable reloads counter
//
// The register addresses and the APB slave port were decided locally.
`timescale 1ns/100ps
module hwd_wdog #(
  parameter int unsigned TICK_CYCLES = hwd_pkg::TICK_CYCLES
) (
  input wire logic mclk, // 50 MHz system clock
  input wire logic reset, // sync reset, high
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb write
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready, no wait
  output logic pslverr, // unmapped address
  input wire logic [7:0] rx_data, // received character
  input wire logic rx_valid, // character strobe
  input wire logic rx_err, // link error strobe
  output logic [7:0] tx_data, // reply character
  output logic tx_valid, // reply character offered
  input wire logic tx_ready, // reply character taken
  output logic dout, // digital output
  output logic irq, // level interrupt
  input wire logic nv_timeout_in, // stored timeout flag
  input wire logic nv_safe_in, // stored safe value
  input wire logic nv_poweron_in, // stored power-on value
  output logic nv_wr, // store flag, one cycle
  output logic nv_wdata // flag value to store
);
  import hwd_pkg::*;

  hwd_rx_t st_q, st_d;
  logic [7:0] buf_q [RX_MAX];
  logic [7:0] buf_d [RX_MAX];
  logic [3:0] len_q, len_d, blen;
  logic done_q, done_d, pdrop;
  logic [7:0] csum, cmd, p1, st_byte;
  logic [4:0] a_hi, a_lo, c_hi, c_lo, v_hi, v_lo;
  logic frame_ok, addr_hit, known, good, act, kick;
  logic clr_cmd, cfg_cmd, cfg_en, fmt_go, tx_busy;
  logic [23:0] pay;
  logic [2:0] plen, rep_len;
  logic [47:0] rep_chars;
  logic tick, tmo;
  logic en_q, en_d, flag_q, flag_d, dout_q, dout_d;
  logic safe_q, safe_d, pon_q, pon_d, load_q;
  logic nv_wr_q, nv_wr_d, nv_dat_q;
  logic [7:0] tenths_q, tenths_d, cnt_q, cnt_d;
  logic [7:0] station_q, station_d;
  logic cks_q, cks_d;
  logic [NEV-1:0] stat_q, stat_d, mask_q, mask_d, ev;
  logic [31:0] prdata_q, prdata_d;
  logic apb_wr, mapped;

  // frame capture; a fresh tilde restarts, overflow is dropped
  always_comb begin
    st_d = st_q;
    buf_d = buf_q;
    len_d = len_q;
    done_d = 1'b0;
    pdrop = 1'b0;
    if (st_q == HWD_BODY && rx_err) begin
      st_d = HWD_IDLE; // [R03]
      pdrop = 1'b1;
    end else if (rx_valid) begin
      unique case (st_q)
        HWD_IDLE: begin
          if (rx_data == CH_TILDE) begin
            st_d = HWD_BODY; // [R01]
            len_d = 4'h0;
          end
        end
        HWD_BODY: begin
          if (rx_data == CH_CR) begin
            st_d = HWD_IDLE; // [R01]
            done_d = 1'b1;
          end else if (rx_data == CH_TILDE) begin
            len_d = 4'h0;
          end else if (len_q == 4'(RX_MAX)) begin
            st_d = HWD_IDLE;
            pdrop = 1'b1;
          end else begin
            buf_d[len_q[2:0]] = rx_data;
            len_d = len_q + 4'h1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      st_q <= HWD_IDLE;
      buf_q <= '{default: 8'h00};
      len_q <= 4'h0;
      done_q <= 1'b0;
    end else begin
      st_q <= st_d;
      buf_q <= buf_d;
      len_q <= len_d;
      done_q <= done_d;
    end
  end

  // frame check: length, hex address, optional sum of the tilde and the body chars before the sum digits
  always_comb begin
    blen = cks_q ? len_q - CKS_CHARS : len_q;
    csum = CH_TILDE;
    for (int i = 0; i < RX_MAX; i++) begin
      if (4'(i) < blen)
        csum = csum + buf_q[i];
    end
    a_hi = hwd_hex_val(buf_q[0]);
    a_lo = hwd_hex_val(buf_q[1]);
    c_hi = hwd_hex_val(buf_q[blen[2:0]]);
    c_lo = hwd_hex_val(buf_q[blen[2:0] + 3'h1]);
    frame_ok = done_q && len_q >= MIN_BODY + (cks_q ? CKS_CHARS : 4'h0)
      && a_hi[4] && a_lo[4]
      && (!cks_q || (c_hi[4] && c_lo[4] && {c_hi[3:0], c_lo[3:0]} == csum)); // [R01]
    addr_hit = frame_ok && {a_hi[3:0], a_lo[3:0]} == station_q; // [R03]
  end

  assign cmd = buf_q[2];
  assign p1 = buf_q[3];
  assign v_hi = hwd_hex_val(buf_q[4]);
  assign v_lo = hwd_hex_val(buf_q[5]);
  assign cfg_en = p1 == CH_1;

  // status byte: enable in bit 7, recorded timeout in bit 2
  always_comb begin
    st_byte = 8'h00; // [R06]
    st_byte[ST_EN_BIT] = en_q; // [R05]
    st_byte[ST_TO_BIT] = flag_q; // [R04]
  end

  // command decode; wrong length or unknown letter stays silent
  always_comb begin
    known = 1'b0;
    good = 1'b1;
    pay = 24'h0;
    plen = 3'h0;
    case (cmd)
      CH_0: begin
        known = blen == 4'h3;
        pay[7:0] = hwd_hex_chr(st_byte[7:4]); // [R04]
        pay[15:8] = hwd_hex_chr(st_byte[3:0]);
        plen = 3'h2;
      end
      CH_1: begin
        known = blen == 4'h3;
      end
      CH_2: begin
        known = blen == 4'h3;
        pay[7:0] = en_q ? CH_1 : CH_0; // [R09]
        pay[15:8] = hwd_hex_chr(tenths_q[7:4]); // [R10]
        pay[23:16] = hwd_hex_chr(tenths_q[3:0]);
        plen = 3'h3;
      end
      CH_3: begin
        known = blen == 4'h6;
        good = (p1 == CH_0 || p1 == CH_1) && v_hi[4] && v_lo[4]; // [R11]
      end
      CH_4: begin
        known = blen == 4'h4;
        good = p1 == CH_P || p1 == CH_S;
        pay[7:0] = hwd_hex_chr({3'h0, p1 == CH_S ? safe_q : pon_q}); // [R13]
        plen = 3'h1;
      end
      default: begin
        known = 1'b0;
      end
    endcase
  end

  // reply text: lead char, own address, payload only when good
  assign act = addr_hit && known; // [R03]
  assign kick = act && good; // [R16]
  assign clr_cmd = kick && cmd == CH_1; // [R08]
  assign cfg_cmd = kick && cmd == CH_3;
  assign rep_chars = {good ? pay : 24'h0, hwd_hex_chr(station_q[3:0]),
    hwd_hex_chr(station_q[7:4]), good ? CH_BANG : CH_QUERY}; // [R02]
  assign rep_len = 3'h3 + (good ? plen : 3'h0);
  // half duplex: a frame finishing during a reply gets no answer
  assign fmt_go = act && !tx_busy;

  hwd_tx u_tx (
    .mclk(mclk),
    .reset(reset),
    .start(fmt_go),
    .chars(rep_chars),
    .len(rep_len),
    .cks_en(cks_q),
    .tx_data(tx_data),
    .tx_valid(tx_valid),
    .tx_ready(tx_ready),
    .busy(tx_busy)
  );

  // tick restarts on a kick, so the full interval always elapses
  hwd_tick #(
    .CYCLES(TICK_CYCLES)
  ) u_tick (
    .mclk(mclk),
    .reset(reset),
    .clr(kick || !en_q),
    .tick(tick)
  );

  assign tmo = en_q && tick && cnt_q <= 8'h01 && !load_q;

  // watchdog state; a same-cycle kick blocks the tick, so a valid command wins over the timeout
  always_comb begin
    en_d = en_q;
    tenths_d = tenths_q;
    cnt_d = cnt_q;
    flag_d = flag_q;
    dout_d = dout_q;
    safe_d = safe_q;
    pon_d = pon_q;
    if (load_q) begin
      flag_d = nv_timeout_in; // [R07]
      safe_d = nv_safe_in;
      pon_d = nv_poweron_in;
      dout_d = nv_poweron_in; // [R15]
    end else begin
      if (apb_wr && paddr == OFS_DOUT)
        dout_d = pwdata[0];
      if (cfg_cmd) begin
        en_d = cfg_en; // [R11]
        tenths_d = {v_hi[3:0], v_lo[3:0]};
      end
      if (clr_cmd)
        flag_d = 1'b0; // [R08]
      if (kick)
        cnt_d = tenths_d; // [R16] [R17]
      else if (en_q && tick)
        cnt_d = cnt_q - 8'h01; // [R17]
      if (tmo) begin
        flag_d = 1'b1; // [R12]
        en_d = 1'b0; // [R12]
        dout_d = safe_q; // [R14]
      end
    end
  end

  // nonvolatile copy follows every flag change
  assign nv_wr_d = !load_q && (tmo || clr_cmd); // [R07]

  always_ff @(posedge mclk) begin
    if (reset) begin
      en_q <= 1'b0;
      tenths_q <= TENTHS_RST;
      cnt_q <= TENTHS_RST;
      flag_q <= 1'b0;
      dout_q <= 1'b0;
      safe_q <= 1'b0;
      pon_q <= 1'b0;
      load_q <= 1'b1;
      nv_wr_q <= 1'b0;
      nv_dat_q <= 1'b0;
    end else begin
      en_q <= en_d;
      tenths_q <= tenths_d;
      cnt_q <= cnt_d;
      flag_q <= flag_d;
      dout_q <= dout_d;
      safe_q <= safe_d;
      pon_q <= pon_d;
      load_q <= 1'b0;
      nv_wr_q <= nv_wr_d;
      nv_dat_q <= flag_d;
    end
  end

  assign dout = dout_q;
  assign nv_wr = nv_wr_q;
  assign nv_wdata = nv_dat_q;

  // apb slave: zero wait, read data latched in the setup cycle
  assign apb_wr = psel && penable && pwrite;
  assign mapped = paddr == OFS_ID || paddr == OFS_WDT || paddr == OFS_DOUT
    || paddr == OFS_STAT || paddr == OFS_MASK;
  assign ev[EV_TIMEOUT] = tmo;
  assign ev[EV_REPLY] = fmt_go;
  assign ev[EV_DROP] = pdrop || (done_q && !act) || (act && tx_busy);

  always_comb begin
    station_d = station_q;
    cks_d = cks_q;
    mask_d = mask_q;
    stat_d = stat_q;
    prdata_d = prdata_q;
    if (apb_wr && paddr == OFS_ID) begin
      station_d = pwdata[7:0];
      cks_d = pwdata[ID_CKS_BIT];
    end
    if (apb_wr && paddr == OFS_MASK)
      mask_d = pwdata[NEV-1:0];
    // write one clears; a new event in the same cycle survives
    if (apb_wr && paddr == OFS_STAT)
      stat_d = stat_q & ~pwdata[NEV-1:0];
    stat_d = stat_d | ev;
    if (psel && !penable && !pwrite) begin
      prdata_d = 32'h0;
      case (paddr)
        OFS_ID: begin
          prdata_d[7:0] = station_q;
          prdata_d[ID_CKS_BIT] = cks_q;
        end
        OFS_WDT: begin
          prdata_d[7:0] = tenths_q;
          prdata_d[WDT_EN_BIT] = en_q;
          prdata_d[WDT_FLAG_BIT] = flag_q;
          prdata_d[WDT_CNT_LSB +: 8] = cnt_q;
        end
        OFS_DOUT: begin
          prdata_d[0] = dout_q;
          prdata_d[DOUT_SAFE_BIT] = safe_q;
          prdata_d[DOUT_PON_BIT] = pon_q;
        end
        OFS_STAT: prdata_d[NEV-1:0] = stat_q;
        OFS_MASK: prdata_d[NEV-1:0] = mask_q;
        default: prdata_d = 32'h0;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      station_q <= STATION_RST;
      cks_q <= 1'b0;
      mask_q <= '0;
      stat_q <= '0;
      prdata_q <= 32'h0;
    end else begin
      station_q <= station_d;
      cks_q <= cks_d;
      mask_q <= mask_d;
      stat_q <= stat_d;
      prdata_q <= prdata_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign irq = |(stat_q & mask_q);

  // checks on the watchdog and reply paths
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  sequence s_expire;
    en_q && tick && cnt_q <= 8'h01 && !load_q;
  endsequence

  sequence s_run;
    en_q && tick && cnt_q > 8'h01 && !kick;
  endsequence

  to_disable_a: assert property (s_expire |=> !en_q && flag_q) // [R12]
    else $error("timeout did not disable and record");
  to_safe_a: assert property (s_expire |=> dout == $past(safe_q)) // [R14]
    else $error("timeout did not apply safe value");
  flag_hold_a: assert property (flag_q && !clr_cmd && !load_q |=> flag_q) // [R07]
    else $error("timeout flag lost without clear command");
  flag_clear_a: assert property (clr_cmd && !tmo |=> !flag_q && nv_wr && !nv_wdata) // [R08]
    else $error("clear command did not clear and store flag");
  pon_load_a: assert property (load_q |=> dout == $past(nv_poweron_in)) // [R15]
    else $error("power-on value not loaded");
  cnt_step_a: assert property (s_run |=> cnt_q == $past(cnt_q) - 8'h01) // [R10]
    else $error("tenths counter did not step");
  kick_reload_a: assert property (kick && !tmo |=> cnt_q == tenths_q) // [R16]
    else $error("countdown not restarted by command");
  silent_a: assert property (done_q && !addr_hit && !tx_busy |=> !tx_valid) // [R03]
    else $error("reply sent for bad or foreign frame");
  reply_start_a: assert property (fmt_go |=> tx_valid && tx_data == $past(rep_chars[7:0])) // [R02]
    else $error("reply did not start with lead character");
  cfg_apply_a: assert property (cfg_cmd && !tmo |=> en_q == $past(cfg_en)) // [R11]
    else $error("configure did not set enable");
endmodule

// ### tb_host_watchdog_cmd.sv
`timescale 1ns/100ps
module tb_host_watchdog_cmd;
  import hwd_pkg::*;
  localparam int unsigned TK = 20; // short tick for simulation
  logic mclk, reset, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, rx_data, tx_data;
  logic [31:0] pwdata, prdata;
  logic rx_valid, rx_err, tx_valid, tx_ready, dout, irq;
  logic nv_to, nv_safe, nv_pon, nv_wr, nv_wdata;
  int n_errors = 0;
  int checked = 0;
  int n_nvset = 0;
  logic [63:0] r;
  logic [31:0] d;
  hwd_wdog #(.TICK_CYCLES(TK)) dut_u (.mclk(mclk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_err(rx_err), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .dout(dout), .irq(irq), .nv_timeout_in(nv_to),
    .nv_safe_in(nv_safe), .nv_poweron_in(nv_pon), .nv_wr(nv_wr), .nv_wdata(nv_wdata));
  hwd_host_model host_u (.mclk(mclk), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_err(rx_err), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready));
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // count stores of a set timeout flag
  always @(posedge mclk) if (nv_wr === 1'b1 && nv_wdata === 1'b1) n_nvset++;
  function automatic logic [63:0] sv(input string s);
    logic [63:0] v;
    v = '0;
    foreach (s[i]) v = {v[55:0], s[i]};
    return v;
  endfunction
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("errors %0d, comparisons %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // apb transfer; answer taken at the rising edge that samples pready high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      rd = prdata;
      err = pslverr;
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    logic e;
    apb(1'b0, a, 32'h0, d, e);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] x;
    logic e;
    apb(1'b1, a, v, x, e);
    // let the write land before callers look at outputs
    @(negedge mclk);
  endtask
  task automatic do_reset();
    @(posedge mclk);
    reset <= 1'b1;
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask
  task automatic t_regs();
    logic e;
    rd(OFS_ID); check(d, 32'h0000_0001);
    rd(OFS_DOUT); check(d, 32'h0000_0021);
    rd(OFS_WDT); check(d, 32'h0);
    apb(1'b0, 8'h20, 32'h0, d, e); check(e, 1'b1);
    host_u.xfer("~010", r); check(r, sv("!0100"));
    // checksum mode: good sum answered with its own sum, bad sum silent
    wr(OFS_ID, 32'h0000_0101);
    host_u.xfer("~0100F", r); check(r, sv("!0100E2"));
    host_u.xfer("~01000", r); check(r, 64'h0);
    wr(OFS_ID, 32'h0000_0001);
  endtask
  task automatic t_refuse();
    host_u.xfer("~0132FF", r); check(r, sv("?01"));
    host_u.xfer("~014X", r); check(r, sv("?01"));
    host_u.xfer("~020", r); check(r, 64'h0);
    host_u.xfer("~01#0", r); check(r, 64'h0);
    host_u.xfer("~01", r); check(r, 64'h0);
    rd(OFS_STAT); check(d[2], 1'b1);
    wr(OFS_MASK, 32'h0); check(irq, 1'b0);
    wr(OFS_MASK, 32'h4); check(irq, 1'b1);
    wr(OFS_STAT, 32'h4); check(irq, 1'b0);
    host_u.xfer("~014P", r); check(r, sv("!011"));
    host_u.xfer("~014S", r); check(r, sv("!010"));
  endtask
  task automatic t_cfg();
    host_u.xfer("~013105", r); check(r, sv("!01"));
    host_u.slow = 1'b1; // reply must wait on a stalling host
    host_u.xfer("~012", r); check(r, sv("!01105"));
    host_u.slow = 1'b0;
    host_u.xfer("~010", r); check(r, sv("!0180"));
  endtask
  task automatic t_timeout();
    wr(OFS_MASK, 32'h1);
    repeat (70) @(posedge mclk);
    rd(OFS_WDT); check(d[9:8], 2'b01);
    repeat (40) @(posedge mclk);
    rd(OFS_WDT); check(d[9:8], 2'b10);
    check(dout, 1'b0);
    check(n_nvset, 1);
    check(irq, 1'b1);
    wr(OFS_STAT, 32'h1); check(irq, 1'b0);
    host_u.xfer("~010", r); check(r, sv("!0104"));
    host_u.xfer("~011", r); check(r, sv("!01"));
    host_u.xfer("~010", r); check(r, sv("!0100"));
  endtask
  // commands faster than three ticks keep the watchdog alive
  task automatic t_keep();
    host_u.xfer("~013103", r); check(r, sv("!01"));
    repeat (6) host_u.xfer("~010", r);
    check(r, sv("!0180"));
    repeat (100) @(posedge mclk);
    rd(OFS_WDT); check(d[9:8], 2'b10);
  endtask
  // stored flag survives a power cycle
  task automatic t_nv();
    nv_to <= 1'b1;
    do_reset();
    host_u.xfer("~010", r); check(r, sv("!0104"));
    check(dout, 1'b1);
  endtask
  initial begin
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    nv_to = 1'b0;
    nv_safe = 1'b0;
    nv_pon = 1'b1;
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    repeat (3) @(posedge mclk);
    t_regs();
    t_refuse();
    t_cfg();
    t_timeout();
    t_keep();
    t_nv();
    tally_and_finish();
  end
  // the whole run takes under 1000 cycles
  initial begin
    #(20 * 8000);
    n_errors++;
    tally_and_finish();
  end
endmodule
